// ===== rtl/dcc_core_ctrl.sv
`timescale 1ns/1ps
module dcc_core_ctrl (
   input  wire logic                               clock_i,
   input  wire logic                               reset_i,
   input  wire logic [dcc_pkg::ADDR_W-1:0]         avs_address_i,
   input  wire logic                               avs_read_i,
   input  wire logic                               avs_write_i,
   input  wire logic [dcc_pkg::DATA_W-1:0]         avs_writedata_i,
   output      logic [dcc_pkg::DATA_W-1:0]         avs_readdata_o,
   output      logic                               avs_waitrequest_o,
   output      logic                               irq_o,
   output      logic [dcc_pkg::NUM_CMP-1:0]        settle_busy_o,
   dcc_if.core                                     bus
);
   // ============================================================
   // Configuration registers
   logic [dcc_pkg::CFG_W-1:0]   cfg_q [dcc_pkg::NUM_CMP];
   logic [1:0]                  pwr_q;
   logic [dcc_pkg::NUM_CMP-1:0] clr_q;
   logic [dcc_pkg::NUM_CMP-1:0] wake_q;
   logic [dcc_pkg::NUM_CMP-1:0] ien_q;
   logic [15:0]                 settle_q [dcc_pkg::NUM_CMP];
   logic                        ack_q;
   logic [dcc_pkg::DATA_W-1:0]  rdata_q;
   logic                        wr;
   logic                        rd;

   // One wait state: read data is captured at the first edge and stands
   // through the second; a write lands only at the completing edge
   assign wr = avs_write_i && ack_q;
   assign rd = avs_read_i && !ack_q;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read_i || avs_write_i) && !ack_q;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
            cfg_q[n] <= dcc_pkg::CFG_RESET;
         end
         pwr_q <= '0;
      end else if (wr && avs_address_i == dcc_pkg::OFS_CTRL) begin
         for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
            cfg_q[n] <= avs_writedata_i[n*dcc_pkg::CFG_W +: dcc_pkg::CFG_W];
         end
      end else if (wr && avs_address_i == dcc_pkg::OFS_POWER) begin
         pwr_q <= avs_writedata_i[1:0];
      end
   end

   // Writing zero to a flag bit clears it; one-cycle pulse
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         clr_q <= '0;
      end else begin
         for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
            clr_q[n] <= wr && avs_address_i == dcc_pkg::OFS_CTRL
                        && !avs_writedata_i[n*dcc_pkg::CFG_W + dcc_pkg::FLD_FLAG];
         end
      end
   end

   // ============================================================
   // Wake event sticky status, clear register and enable register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wake_q <= '0;
         ien_q  <= '0;
      end else begin
         for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
            if (bus.wake && bus.cmp_change_flag[n] && cfg_q[n][dcc_pkg::FLD_CMP_IE]) begin
               wake_q[n] <= 1'b1;
            end else if (wr && avs_address_i == dcc_pkg::OFS_IRQ_CLR && avs_writedata_i[n]) begin
               wake_q[n] <= 1'b0;
            end
         end
         if (wr && avs_address_i == dcc_pkg::OFS_IRQ_EN) begin
            ien_q <= avs_writedata_i[dcc_pkg::NUM_CMP-1:0];
         end
      end
   end

   // Settling guard: interrupt held off after enable
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
            settle_q[n] <= '0;
         end
      end else begin
         for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
            if (!cfg_q[n][dcc_pkg::FLD_ENABLE]) begin
               settle_q[n] <= 16'(dcc_pkg::SETTLE_CYC); // R6
            end else if (settle_q[n] != 16'h0000) begin
               settle_q[n] <= settle_q[n] - 16'h0001;
            end
         end
      end
   end

   always_comb begin
      for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
         bus.enable[n]     = cfg_q[n][dcc_pkg::FLD_ENABLE];
         bus.pos_sel[n]    = cfg_q[n][dcc_pkg::FLD_POS_SEL];
         bus.neg_sel[n]    = cfg_q[n][dcc_pkg::FLD_NEG_SEL];
         bus.pin_out_en[n] = cfg_q[n][dcc_pkg::FLD_PIN_OUT];
         // Interrupt off while settling after enable; a disabled unit still
         // reports its forced-high edge
         bus.irq_en[n]     = cfg_q[n][dcc_pkg::FLD_CMP_IE]
                             && (!cfg_q[n][dcc_pkg::FLD_ENABLE] || settle_q[n] == 16'h0000); // R6 R8
         settle_busy_o[n]  = settle_q[n] != 16'h0000;
      end
   end

   assign bus.flag_clr          = clr_q;
   assign bus.power_gating_ctrl = pwr_q[dcc_pkg::PW_GATE];
   assign bus.pmode = pwr_q[dcc_pkg::PW_TOTAL_PD] ? dcc_pkg::DCC_PM_TOTAL_PD : dcc_pkg::DCC_PM_RUN;
   assign irq_o = bus.irq || |(wake_q & ien_q); // R5

   // ============================================================
   // Read data
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rdata_q <= '0;
      end else if (rd) begin
         rdata_q <= '0;
         unique case (avs_address_i)
            dcc_pkg::OFS_CTRL: begin
               for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
                  rdata_q[n*dcc_pkg::CFG_W +: dcc_pkg::CFG_W] <= cfg_q[n]
                     | (8'(bus.cmp_change_flag[n]) << dcc_pkg::FLD_FLAG);
               end
            end
            dcc_pkg::OFS_STATUS: begin
               rdata_q[dcc_pkg::ST_RESULT +: dcc_pkg::NUM_CMP] <= bus.cmp_result_bit;
               rdata_q[dcc_pkg::ST_FLAG +: dcc_pkg::NUM_CMP]   <= bus.cmp_change_flag; // R4
               rdata_q[dcc_pkg::ST_WAKE +: dcc_pkg::NUM_CMP]   <= wake_q;
            end
            dcc_pkg::OFS_IRQ_EN: rdata_q[dcc_pkg::NUM_CMP-1:0] <= ien_q;
            dcc_pkg::OFS_POWER:  rdata_q[1:0] <= pwr_q;
            default:             rdata_q <= '0;
         endcase
      end
   end

   assign avs_readdata_o = rdata_q;
endmodule

// ===== common/dcc_pkg.sv
package dcc_pkg;
   // ============================================================
   // Sizes
   localparam int unsigned NUM_CMP      = 2;
   localparam int unsigned DATA_W       = 32;
   localparam int unsigned ADDR_W       = 4;

   // ============================================================
   // Register word offsets (Avalon word addresses)
   localparam logic [3:0] OFS_CTRL      = 4'h0;
   localparam logic [3:0] OFS_STATUS    = 4'h1;
   localparam logic [3:0] OFS_IRQ_EN    = 4'h2;
   localparam logic [3:0] OFS_IRQ_CLR   = 4'h3;
   localparam logic [3:0] OFS_POWER     = 4'h4;

   // ============================================================
   // Per-comparator configuration fields (byte n of ctrl word)
   localparam int unsigned FLD_ENABLE    = 0;
   localparam int unsigned FLD_POS_SEL   = 1;
   localparam int unsigned FLD_NEG_SEL   = 2;
   localparam int unsigned FLD_PIN_OUT   = 3;
   localparam int unsigned FLD_CMP_IE    = 4;
   localparam int unsigned FLD_FLAG      = 5;
   localparam int unsigned CFG_W         = 8;

   // Status word fields
   localparam int unsigned ST_RESULT     = 0;
   localparam int unsigned ST_FLAG       = 2;
   localparam int unsigned ST_WAKE       = 4;

   // Power word fields
   localparam int unsigned PW_GATE       = 0;
   localparam int unsigned PW_TOTAL_PD   = 1;

   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

   // Settling time before the interrupt may be enabled
   localparam int unsigned SETTLE_US     = 10;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned SETTLE_CYC    = SETTLE_US * CLK_MHZ;

   typedef enum logic [1:0] {
      DCC_PM_RUN,
      DCC_PM_IDLE,
      DCC_PM_PD,
      DCC_PM_TOTAL_PD
   } dcc_pmode_t;
endpackage

// ===== common/dcc_if.sv
`timescale 1ns/1ps
interface dcc_if;
   // Per-comparator configuration and shared power controls from the core
   logic [dcc_pkg::NUM_CMP-1:0] enable;
   logic [dcc_pkg::NUM_CMP-1:0] pos_sel;
   logic [dcc_pkg::NUM_CMP-1:0] neg_sel;
   logic [dcc_pkg::NUM_CMP-1:0] pin_out_en;
   logic [dcc_pkg::NUM_CMP-1:0] irq_en;
   logic [dcc_pkg::NUM_CMP-1:0] flag_clr;
   logic                        power_gating_ctrl;
   dcc_pkg::dcc_pmode_t         pmode;
   // Results back to the core
   logic [dcc_pkg::NUM_CMP-1:0] cmp_result_bit;
   logic [dcc_pkg::NUM_CMP-1:0] cmp_change_flag;
   logic                        irq;
   logic                        wake;

   modport comparator (
      input  enable, pos_sel, neg_sel, pin_out_en, irq_en, flag_clr, power_gating_ctrl, pmode,
      output cmp_result_bit, cmp_change_flag, irq, wake
   );
   modport core (
      output enable, pos_sel, neg_sel, pin_out_en, irq_en, flag_clr, power_gating_ctrl, pmode,
      input  cmp_result_bit, cmp_change_flag, irq, wake
   );
endinterface

// ===== rtl/dcc_comparator.sv
`timescale 1ns/1ps
// Behaviour
// R1: Enabled output is one when plus exceeds minus
// R2: Plus picks two pins, minus pin or reference
// R3: Any output change sets that comparator's flag
// R4: Flag pollable and gated onto interrupt
// R5: Both comparators share one interrupt line
// R6: Software waits settling, clears flag first
// R7: Disabled comparator output forced high
// R8: Low output on disable sets flag
// R9: Software disables interrupt before comparator
// R10: Idle and power-down keep; total off
// R11: Enabled change raises interrupt and wake
// R12: Power gating bit disables both comparators
// R13: Software uses push-pull for pin output
// R14: Analog result double-synchronised before edge detect
// R15: Flag stays until cleared; irq ORs
module dcc_comparator (
   input  wire logic                        clock_i,
   input  wire logic                        reset_i,
   input  wire logic [dcc_pkg::NUM_CMP-1:0] pos_a_i,
   input  wire logic [dcc_pkg::NUM_CMP-1:0] pos_b_i,
   input  wire logic [dcc_pkg::NUM_CMP-1:0] neg_pin_i,
   input  wire logic [dcc_pkg::NUM_CMP-1:0] neg_ref_i,
   output      logic [dcc_pkg::NUM_CMP-1:0] pos_gt_a_o,
   output      logic [dcc_pkg::NUM_CMP-1:0] pin_o,
   output      logic [dcc_pkg::NUM_CMP-1:0] pin_oe_o,
   dcc_if.comparator                        bus
);
   // ============================================================
   // Analog compare selection
   // Each *_i is a digital compare outcome from the analog front end:
   // pos_a_i/pos_b_i is plus pin A/B above minus pin, neg_ref_i marks
   // whether the selected plus pin is above the reference.
   logic [dcc_pkg::NUM_CMP-1:0]   raw;
   logic [3*dcc_pkg::NUM_CMP-1:0] s1_q;
   logic [3*dcc_pkg::NUM_CMP-1:0] s2_q;
   logic [dcc_pkg::NUM_CMP-1:0]   active;
   logic [dcc_pkg::NUM_CMP-1:0]   result_d;
   logic [dcc_pkg::NUM_CMP-1:0]   result_q;
   logic [dcc_pkg::NUM_CMP-1:0]   flag_q;

   always_comb begin
      for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
         if (bus.neg_sel[n]) begin
            raw[n] = s2_q[2*dcc_pkg::NUM_CMP + n]; // R2
         end else if (bus.pos_sel[n]) begin
            raw[n] = s2_q[dcc_pkg::NUM_CMP + n]; // R2
         end else begin
            raw[n] = s2_q[n];
         end
      end
   end

   assign pos_gt_a_o = raw;

   // ============================================================
   // Enables and power modes
   // Total power-down and the gating bit both override per-unit enables
   always_comb begin
      for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
         active[n] = bus.enable[n] && !bus.power_gating_ctrl // R12
                     && (bus.pmode != dcc_pkg::DCC_PM_TOTAL_PD); // R10
      end
   end

   // ============================================================
   // Synchroniser ahead of the select mux, so no logic ever
   // sees an analog outcome that is still settling
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {neg_ref_i, pos_b_i, pos_a_i}; // R14
         s2_q <= s1_q; // R14
      end
   end

   // ============================================================
   // Output bit
   always_comb begin
      for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
         result_d[n] = active[n] ? raw[n] : 1'b1; // R1 R7
      end
   end

   // Reset value high matches a disabled comparator
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         result_q <= '1;
      end else begin
         result_q <= result_d;
      end
   end

   // ============================================================
   // Change flags, set wins over clear
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         flag_q <= '0;
      end else begin
         for (int n = 0; n < dcc_pkg::NUM_CMP; n++) begin
            if (result_d[n] != result_q[n]) begin
               flag_q[n] <= 1'b1; // R3 R8
            end else if (bus.flag_clr[n]) begin
               flag_q[n] <= 1'b0; // R15
            end
         end
      end
   end

   assign bus.cmp_result_bit  = result_q; // R1
   assign bus.cmp_change_flag = flag_q; // R4
   assign bus.irq  = |(flag_q & bus.irq_en); // R5 R15
   assign bus.wake = bus.irq && (bus.pmode != dcc_pkg::DCC_PM_TOTAL_PD); // R11
   assign pin_o    = result_q;
   assign pin_oe_o = bus.pin_out_en & active; // R13
endmodule

// ===== verif/dcc_asserts.sv
`timescale 1ns/1ps
module dcc_asserts (
   input wire logic                clock_i,
   input wire logic                reset_i,
   input wire logic [1:0]          enable,
   input wire logic [1:0]          irq_en,
   input wire logic [1:0]          flag_clr,
   input wire logic                power_gating_ctrl,
   input wire dcc_pkg::dcc_pmode_t pmode,
   input wire logic [1:0]          cmp_result_bit,
   input wire logic [1:0]          cmp_change_flag,
   input wire logic                irq
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // ==========================================================
   // Output bit and change flags
   off_high_a: assert property ((~enable & $past(~enable) & ~cmp_result_bit) == 2'h0)
      else $error("disabled output low");
   flag_set_a: assert property (((cmp_result_bit ^ $past(cmp_result_bit)) & ~cmp_change_flag) == 2'h0)
      else $error("change without flag");
   flag_cause_a: assert property ((cmp_change_flag & ~$past(cmp_change_flag)
      & ~(cmp_result_bit ^ $past(cmp_result_bit))) == 2'h0)
      else $error("flag without change");
   flag_sticky_a: assert property (($past(cmp_change_flag & ~flag_clr) & ~cmp_change_flag) == 2'h0)
      else $error("flag lost");
   flag_clear_a: assert property (($past(flag_clr) & cmp_change_flag
      & ~(cmp_result_bit ^ $past(cmp_result_bit))) == 2'h0)
      else $error("flag not cleared");
   // ==========================================================
   // Interrupt and power
   irq_or_a: assert property (pmode != dcc_pkg::DCC_PM_TOTAL_PD |-> irq == |(cmp_change_flag & irq_en))
      else $error("irq mismatch");
   total_off_a: assert property ((pmode == dcc_pkg::DCC_PM_TOTAL_PD) [*2] |-> &cmp_result_bit)
      else $error("total power down output low");
   gate_off_a: assert property (power_gating_ctrl [*2] |-> &cmp_result_bit)
      else $error("gated output low");
   cover property ($rose(irq));
   cover property (flag_clr != 2'h0);
   cover property (pmode == dcc_pkg::DCC_PM_TOTAL_PD);
endmodule

// ===== verif/dual_comparator_control_irq_bench.sv
`timescale 1ns/1ps
module dual_comparator_control_irq_bench;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [1:0]  pos_a_i = 2'h0;
   logic [1:0]  pos_b_i = 2'h0;
   logic [1:0]  neg_ref_i = 2'h0;
   logic [3:0]  avs_address_i = 4'h0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        irq_o;
   logic [1:0]  settle_busy_o;
   logic [1:0]  pin_o;
   logic [1:0]  pin_oe_o;
   logic [1:0]  pos_gt_a_o;
   logic [31:0] rd;
   int          fail_count = 0;
   int          checked = 0;
   dcc_if bus ();
   always #5 clock_i = ~clock_i;
   dcc_comparator dcc_comparator_i (.clock_i(clock_i), .reset_i(reset_i), .pos_a_i(pos_a_i), .pos_b_i(pos_b_i),
      .neg_pin_i(2'h0), .neg_ref_i(neg_ref_i), .pos_gt_a_o(pos_gt_a_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .bus(bus));
   dcc_core_ctrl dcc_core_ctrl_i (.clock_i(clock_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
      .settle_busy_o(settle_busy_o), .bus(bus));
   dcc_asserts dcc_asserts_i (.clock_i(clock_i), .reset_i(reset_i), .enable(bus.enable), .irq_en(bus.irq_en),
      .flag_clr(bus.flag_clr), .power_gating_ctrl(bus.power_gating_ctrl), .pmode(bus.pmode),
      .cmp_result_bit(bus.cmp_result_bit), .cmp_change_flag(bus.cmp_change_flag), .irq(bus.irq));
   // ==========================================================
   // Shared tasks
   task automatic final_report();
      if (fail_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // Waitrequest and read data taken at the rising edge, before its updates
   task automatic bus_op(input logic w, input logic [3:0] a, input logic [31:0] d);
      int   n;
      logic busy;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      do begin
         @(posedge clock_i);
         busy = avs_waitrequest_o;
         n++;
         if (n > 50) begin
            fail_count++;
            final_report();
         end
      end while (busy !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus_op(1'b1, a, d);
      wt(5);
   endtask
   task automatic rs(input logic [31:0] m, input logic [31:0] e);
      bus_op(1'b0, dcc_pkg::OFS_STATUS, 32'h0);
      chk(rd & m, e);
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_idle();
      rs(32'hf, 32'h3);
      bus_op(1'b0, 4'hf, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, irq_o}, 32'h0);
   endtask
   task automatic t_enable();
      int n;
      n = 0;
      wr(dcc_pkg::OFS_CTRL, 32'h0101);
      chk({30'h0, settle_busy_o}, 32'h3);
      while (settle_busy_o !== 2'h0 && n < 1100) begin
         n++;
         @(posedge clock_i);
      end
      chk(32'(n >= 1100), 32'h0);
      if (n >= 1100) final_report();
      rs(32'h3, 32'h0);
      wr(dcc_pkg::OFS_CTRL, 32'h0101);
      rs(32'hf, 32'h0);
   endtask
   task automatic t_select();
      logic [7:0] b;
      logic [1:0] s;
      for (int m = 0; m < 3; m++) begin
         b = 8'h09 | (m == 1 ? 8'h02 : 8'h00) | (m == 2 ? 8'h04 : 8'h00);
         wr(dcc_pkg::OFS_CTRL, {16'h0, b, b});
         for (int l = 0; l < 2; l++) begin
            s = (l == 1) ? 2'h3 : 2'h0;
            pos_a_i <= (m == 0) ? s : ~s;
            pos_b_i <= (m == 1) ? s : ~s;
            neg_ref_i <= (m == 2) ? s : ~s;
            wt(6);
            rs(32'h3, {30'h0, s});
            chk({26'h0, pin_oe_o, pin_o, pos_gt_a_o}, {26'h0, 2'h3, s, s});
         end
      end
   endtask
   task automatic t_irq();
      wr(dcc_pkg::OFS_CTRL, 32'h0101);
      wr(dcc_pkg::OFS_CTRL, 32'h0101);
      wr(dcc_pkg::OFS_CTRL, 32'h1101);
      wr(dcc_pkg::OFS_IRQ_EN, 32'h2);
      wr(dcc_pkg::OFS_IRQ_CLR, 32'h3);
      pos_a_i <= 2'h1;
      wt(6);
      chk({31'h0, irq_o}, 32'h0);
      rs(32'hf, 32'h5);
      pos_a_i <= 2'h3;
      wt(6);
      chk({31'h0, irq_o}, 32'h1);
      rs(32'hf, 32'hf);
      rs(32'h30, 32'h20);
      wr(dcc_pkg::OFS_CTRL, 32'h3101);
      rs(32'hf, 32'hb);
      chk({31'h0, irq_o}, 32'h1);
      wr(dcc_pkg::OFS_CTRL, 32'h1101);
      chk({31'h0, irq_o}, 32'h1);
      wr(dcc_pkg::OFS_IRQ_CLR, 32'h2);
      chk({31'h0, irq_o}, 32'h0);
   endtask
   task automatic t_disable();
      wr(dcc_pkg::OFS_CTRL, 32'h0101);
      pos_a_i <= 2'h0;
      wt(6);
      wr(dcc_pkg::OFS_CTRL, 32'h0101);
      wr(dcc_pkg::OFS_CTRL, 32'h1111);
      wr(dcc_pkg::OFS_IRQ_EN, 32'h3);
      wr(dcc_pkg::OFS_IRQ_CLR, 32'h3);
      chk({31'h0, irq_o}, 32'h0);
      wr(dcc_pkg::OFS_CTRL, 32'h1110);
      rs(32'hf, 32'h5);
      chk({31'h0, irq_o}, 32'h1);
      wr(dcc_pkg::OFS_CTRL, 32'h0100);
      wr(dcc_pkg::OFS_IRQ_CLR, 32'h3);
      wr(dcc_pkg::OFS_CTRL, 32'h0000);
      chk({31'h0, irq_o}, 32'h0);
      wr(dcc_pkg::OFS_CTRL, 32'h0000);
      rs(32'hf, 32'h3);
   endtask
   task automatic t_power();
      wr(dcc_pkg::OFS_CTRL, 32'h0101);
      rs(32'h3, 32'h0);
      wr(dcc_pkg::OFS_POWER, 32'h2);
      rs(32'h3, 32'h3);
      wr(dcc_pkg::OFS_POWER, 32'h0);
      rs(32'h3, 32'h0);
      wr(dcc_pkg::OFS_POWER, 32'h1);
      rs(32'h3, 32'h3);
      wr(dcc_pkg::OFS_POWER, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      t_idle();
      t_enable();
      t_select();
      t_irq();
      t_disable();
      t_power();
      final_report();
   end
endmodule
